// *** common/sgr_pkg.sv ***
// Shared constants for the status group reporter.
// Assumes a 100 MHz clock and a 17-bit information word per telemetry word.
package sgr_pkg;
    // ****************************************
    // Word layout
    // ****************************************
    localparam int INFO_BITS = 17;
    localparam int PAR_BITS = 7;
    localparam int ADDR_LSB = 9;
    localparam int ADDR_W = 8;
    localparam int GROUP_LSB = 4;
    localparam int GROUP_W = 4;
    localparam int CMD_BIT = 3;
    localparam int SUB_W = 4;
    localparam int STATUS_W = 16;
    localparam int NUM_GROUPS = 16;
    localparam int NUM_SUBS = 16;
    localparam int NUM_POINTS = 4096;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int STEP_MS = 100;
    localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
    localparam int SETTLE_MS = 20;
    localparam int SETTLE_CYCLES = CLK_HZ / 1000 * SETTLE_MS;
    localparam int RELEASE_MS = 20;
    localparam int RELEASE_CYCLES = CLK_HZ / 1000 * RELEASE_MS;
    localparam logic [3:0] SUB_LAST = 4'hf;
    typedef enum logic [1:0] {SGR_IDLE, SGR_SETTLE, SGR_WAIT, SGR_RELEASE} sgr_state_t;
endpackage : sgr_pkg

// *** src/sgr_fifo.sv ***
// Word FIFO between the group transmitter and the transmission control unit.
// Assumes one clock; both sides use valid/ready.
module sgr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = cnt_reg < (AW+1)'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data = mem[rd_reg];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sgr_fifo

// *** src/sgr_top.sv ***
// Status group reporter of a remote station: request decode, matrix stepping,
// reply word loading and eavesdrop storage.
// Assumes the transmission control unit delivers checked-in 17-bit words with parity.
// Function
// - Bit 3 set marks group report command
// - Parity then address checked before processing
// - Group number held in 4-bit store
// - Status space 4096 points, 16x16x16
// - Group column, subgroup row select element
// - Selected element gives 16 parallel bits
// - Column held while subgroups count 0..15
// - Subgroup steps about ten per second
// - Each step loads one 16-bit status word
// - Settle delay before loading enabled subgroup
// - Release delay before next element, no interleave
// - Interleaving omits the release delay
// - Only addressed remote replies, sixteen words
// - Eavesdrop request forwards address and group
// - Eavesdrop receiver arms to count replies
// - Storage enabled by station and subgroup; the group is not compared
// - Received word broadcast, one unit loads
// - Stored bits drive display outputs
// - Parity mismatch discards word silently
// - Seventeen information bits per word
module sgr_top
    import sgr_pkg::*;
#(
    parameter int STEP_CNT = STEP_CYCLES,
    parameter int SETTLE_CNT = SETTLE_CYCLES,
    parameter int RELEASE_CNT = RELEASE_CYCLES,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Configuration
    input wire logic [ADDR_W-1:0] own_addr,
    input wire logic [ADDR_W-1:0] watch_addr,
    input wire logic watch_en,
    input wire logic interleave_en,
    // Received words from the transmission control unit
    input wire logic [INFO_BITS-1:0] rx_info,
    input wire logic [PAR_BITS-1:0] rx_parity,
    input wire logic rx_valid,
    // Status matrix
    output logic [GROUP_W-1:0] col_sel,
    output logic col_en,
    output logic [SUB_W-1:0] row_sel,
    output logic row_en,
    input wire logic [STATUS_W-1:0] status_in,
    // Words toward the transmission control unit
    output logic [STATUS_W-1:0] tx_word,
    output logic tx_valid,
    input wire logic tx_ready,
    // Eavesdrop storage outputs and busy flag (report or eavesdrop active)
    output logic [NUM_SUBS*STATUS_W-1:0] store_out,
    output logic busy
);
    // ****************************************
    // Parity and decode
    // ****************************************
    // Each parity bit covers info bits whose index mod 7 matches
    function automatic logic [PAR_BITS-1:0] gen_par(input logic [INFO_BITS-1:0] d);
        logic [PAR_BITS-1:0] p;
        p = '0;
        for (int i = 0; i < INFO_BITS; i++) begin
            p[i % PAR_BITS] ^= d[i];
        end
        return p;
    endfunction : gen_par

    wire par_ok = gen_par(rx_info) == rx_parity;
    wire word_ok = rx_valid && par_ok;
    wire is_cmd = rx_info[CMD_BIT];
    wire [ADDR_W-1:0] w_addr = rx_info[ADDR_LSB +: ADDR_W];
    wire [GROUP_W-1:0] w_group = rx_info[GROUP_LSB +: GROUP_W];
    wire [STATUS_W-1:0] w_data = rx_info[STATUS_W-1:0];
    wire own_req = word_ok && is_cmd && (w_addr == own_addr);
    wire spy_req = word_ok && is_cmd && watch_en && (w_addr == watch_addr);

    // ****************************************
    // Group transmitter
    // ****************************************
    sgr_state_t st_reg, st_next;
    logic [GROUP_W-1:0] grp_reg;
    logic [SUB_W-1:0] sub_reg;
    logic [31:0] tmr_reg;
    logic fifo_in_ready;
    logic load_reg;
    logic [STATUS_W-1:0] load_word_reg;
    logic spy_act_reg;
    wire tmr_done = tmr_reg == 32'h0;
    wire last_sub = sub_reg == SUB_LAST;
    // Step spacing never shorter than one full settle
    wire [31:0] step_gap = (STEP_CNT > SETTLE_CNT) ? 32'(STEP_CNT - SETTLE_CNT) : 32'h1;

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            SGR_IDLE: if (own_req) st_next = SGR_SETTLE;
            SGR_SETTLE: if (tmr_done && fifo_in_ready) st_next = SGR_WAIT;
            SGR_WAIT: begin
                if (tmr_done) begin
                    if (last_sub) st_next = SGR_IDLE;
                    else if (interleave_en) st_next = SGR_SETTLE;
                    else st_next = SGR_RELEASE;
                end
            end
            SGR_RELEASE: if (tmr_done) st_next = SGR_SETTLE;
            default: st_next = SGR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= SGR_IDLE;
            grp_reg <= '0;
            sub_reg <= '0;
            tmr_reg <= '0;
        end else begin
            st_reg <= st_next;
            if (st_reg == SGR_IDLE && own_req) begin
                grp_reg <= w_group;
                sub_reg <= '0;
                tmr_reg <= 32'(SETTLE_CNT);
            end else if (st_reg == SGR_SETTLE && tmr_done && fifo_in_ready) begin
                tmr_reg <= step_gap;
            end else if (st_reg == SGR_WAIT && tmr_done) begin
                if (!last_sub) sub_reg <= sub_reg + 1'b1;
                tmr_reg <= interleave_en ? 32'(SETTLE_CNT) : 32'(RELEASE_CNT);
            end else if (st_reg == SGR_RELEASE && tmr_done) begin
                tmr_reg <= 32'(SETTLE_CNT);
            end else if (!tmr_done) begin
                tmr_reg <= tmr_reg - 32'h1;
            end
        end
    end

    // Load gate: one status word per subgroup step
    always_ff @(posedge clk) begin
        if (srst) begin
            load_reg <= 1'b0;
            load_word_reg <= '0;
        end else begin
            load_reg <= (st_reg == SGR_SETTLE) && tmr_done && fifo_in_ready;
            load_word_reg <= status_in;
        end
    end

    // ****************************************
    // Matrix drive
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            col_sel <= '0;
            col_en <= 1'b0;
            row_sel <= '0;
            row_en <= 1'b0;
            busy <= 1'b0;
        end else begin
            // Enables follow the state register so a stale column or row never lights
            col_sel <= grp_reg;
            col_en <= st_reg != SGR_IDLE;
            row_sel <= sub_reg;
            row_en <= (st_reg == SGR_SETTLE) || (st_reg == SGR_WAIT);
            busy <= (st_next != SGR_IDLE) || spy_act_reg;
        end
    end

    // ****************************************
    // Reply buffer
    // ****************************************
    logic [STATUS_W-1:0] fifo_data;
    logic fifo_valid;

    sgr_fifo #(
        .WIDTH(STATUS_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_data(load_word_reg),
        .in_valid(load_reg),
        .in_ready(fifo_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(!tx_valid || tx_ready)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_valid <= 1'b0;
            tx_word <= '0;
        end else if (!tx_valid || tx_ready) begin
            tx_valid <= fifo_valid;
            tx_word <= fifo_data;
        end
    end

    // ****************************************
    // Eavesdrop receiver
    // ****************************************
    logic [SUB_W-1:0] spy_sub_reg;
    logic [GROUP_W-1:0] spy_grp_reg;
    wire spy_word = spy_act_reg && word_ok && !is_cmd;

    always_ff @(posedge clk) begin
        if (srst) begin
            spy_act_reg <= 1'b0;
            spy_sub_reg <= '0;
            spy_grp_reg <= '0;
        end else if (spy_req) begin
            spy_act_reg <= 1'b1;
            spy_sub_reg <= '0;
            spy_grp_reg <= w_group;
        end else if (spy_word) begin
            spy_sub_reg <= spy_sub_reg + 1'b1;
            if (spy_sub_reg == SUB_LAST) spy_act_reg <= 1'b0;
        end
    end

    // Storage for the watched group: one unit per subgroup
    for (genvar s = 0; s < NUM_SUBS; s++) begin : g_store
        wire unit_en = spy_word && (spy_sub_reg == SUB_W'(s));
        always_ff @(posedge clk) begin
            if (srst) begin
                store_out[s*STATUS_W +: STATUS_W] <= '0;
            end else if (unit_en) begin
                store_out[s*STATUS_W +: STATUS_W] <= w_data;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_settle_done;
        (st_reg == SGR_SETTLE) && tmr_done && fifo_in_ready;
    endsequence

    AST_BAD_PARITY: assert property (@(posedge clk) disable iff (srst)
        (st_reg == SGR_IDLE) && rx_valid && !par_ok |=> st_reg == SGR_IDLE)
        else $error("bad parity word started a report");
    AST_CMD_START: assert property (@(posedge clk) disable iff (srst)
        (st_reg == SGR_IDLE) && own_req |=> (st_reg == SGR_SETTLE) ##1 col_en)
        else $error("valid request did not start report");
    AST_NO_CMD_BIT: assert property (@(posedge clk) disable iff (srst)
        (st_reg == SGR_IDLE) && !is_cmd |=> st_reg == SGR_IDLE)
        else $error("non-command word started report");
    AST_GROUP_HELD: assert property (@(posedge clk) disable iff (srst)
        (st_reg != SGR_IDLE) |=> $stable(grp_reg))
        else $error("group changed during report");
    AST_LOAD: assert property (@(posedge clk) disable iff (srst)
        s_settle_done |=> load_reg ##1 1'b1)
        else $error("status word not loaded after settle");
    AST_SETTLE_MIN: assert property (@(posedge clk) disable iff (srst)
        $rose(st_reg == SGR_SETTLE) |-> !load_reg [*2])
        else $error("load without settle delay");
    AST_END: assert property (@(posedge clk) disable iff (srst)
        (st_reg == SGR_WAIT) && tmr_done && last_sub |=> st_reg == SGR_IDLE)
        else $error("report did not end after last subgroup");
    AST_INTERLEAVE: assert property (@(posedge clk) disable iff (srst)
        (st_reg == SGR_WAIT) && tmr_done && !last_sub && interleave_en |=> st_reg == SGR_SETTLE)
        else $error("release delay used with interleave");
    AST_SPY_END: assert property (@(posedge clk) disable iff (srst)
        spy_word && (spy_sub_reg == SUB_LAST) && !spy_req |=> !spy_act_reg)
        else $error("eavesdrop did not idle after last word");
endmodule : sgr_top

// *** testbench/sgr_central.sv ***
// Central station model: sends telemetry words, takes reply words.
// Assumes the reporter samples on the rising edge.
module sgr_central
    import sgr_pkg::*;
(
    // Clock
    input wire logic clk,
    // Request side
    output logic [INFO_BITS-1:0] rx_info,
    output logic [PAR_BITS-1:0] rx_parity,
    output logic rx_valid,
    // Reply side
    input wire logic [STATUS_W-1:0] tx_word,
    input wire logic tx_valid,
    output logic tx_ready,
    // Stall control
    input wire logic stall
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [STATUS_W-1:0] got[$];
    function automatic logic [PAR_BITS-1:0] par_of(input logic [INFO_BITS-1:0] w);
        logic [PAR_BITS-1:0] p;
        p = '0;
        for (int i = 0; i < INFO_BITS; i++) p[i % PAR_BITS] ^= w[i];
        return p;
    endfunction : par_of
    task automatic send_word(input logic [INFO_BITS-1:0] w, input logic corrupt);
        @(negedge clk);
        rx_info = w;
        rx_parity = par_of(w) ^ {6'h00, corrupt};
        rx_valid = 1'b1;
        @(negedge clk);
        rx_valid = 1'b0;
        // Released lines show the inverse, not a stale copy
        rx_info = ~w;
        rx_parity = ~rx_parity;
    endtask : send_word
    initial begin
        rx_info = '0;
        rx_parity = '0;
        rx_valid = 1'b0;
    end
    assign tx_ready = !stall;
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_word);
    end
endmodule : sgr_central

// *** testbench/testbench.sv ***
// Self-checking bench for the status group reporter.
// Assumes short step, settle and release counts.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sgr_pkg::*;
    localparam int STEP = 40;
    localparam int REL = 5;
    logic clk = 1'b0, srst, watch_en, interleave_en, stall, rx_valid, col_en, row_en, tx_valid, tx_ready, busy;
    logic [7:0] own_addr, watch_addr;
    logic [16:0] rx_info;
    logic [6:0] rx_parity;
    logic [3:0] col_sel, row_sel;
    logic [15:0] status_in, tx_word, mval;
    logic [255:0] store_out;
    int bad_count = 0, comparisons = 0, cyc_a, cyc_b, cyc_c;
    always #5 clk = ~clk;
    // Unselected relays show the inverse so a stale read shows up
    assign mval = {4'ha, col_sel, 4'h0, row_sel};
    assign status_in = row_en ? mval : ~mval;
    sgr_top #(.STEP_CNT(STEP), .SETTLE_CNT(10), .RELEASE_CNT(REL), .FIFO_DEPTH(8)) sgr_top_inst (
        .clk(clk), .srst(srst), .own_addr(own_addr), .watch_addr(watch_addr), .watch_en(watch_en),
        .interleave_en(interleave_en), .rx_info(rx_info), .rx_parity(rx_parity), .rx_valid(rx_valid),
        .col_sel(col_sel), .col_en(col_en), .row_sel(row_sel), .row_en(row_en), .status_in(status_in),
        .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .store_out(store_out), .busy(busy));
    sgr_central sgr_central_inst (
        .clk(clk), .rx_info(rx_info), .rx_parity(rx_parity), .rx_valid(rx_valid),
        .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .stall(stall));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic finish_test;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    task automatic refused;
        sgr_central_inst.send_word({own_addr, 1'b0, 4'h3, 1'b1, 3'h0}, 1'b1);
        sgr_central_inst.send_word({8'h7e, 1'b0, 4'h3, 1'b1, 3'h0}, 1'b0);
        sgr_central_inst.send_word({own_addr, 1'b0, 4'h3, 1'b0, 3'h0}, 1'b0);
        repeat (20) @(negedge clk);
        check("busy", busy, 0);
        check("col_en", col_en, 0);
        check("words", sgr_central_inst.got.size(), 0);
    endtask : refused
    task automatic run_report(input logic [3:0] grp, input int hold, output int cyc);
        int col_bad;
        col_bad = 0;
        cyc = 0;
        sgr_central_inst.got.delete();
        stall = (hold > 0);
        sgr_central_inst.send_word({own_addr, 1'b0, grp, 1'b1, 3'h0}, 1'b0);
        repeat (3) @(negedge clk);
        check("col_en", col_en, 1);
        while ((busy !== 1'b0 || col_en !== 1'b0 || sgr_central_inst.got.size() < 16) && cyc < 5000) begin
            @(negedge clk);
            cyc++;
            if (cyc == hold) stall = 1'b0;
            if (cyc == 100) sgr_central_inst.send_word({own_addr, 1'b0, ~grp, 1'b1, 3'h0}, 1'b0);
            if (col_en === 1'b1 && col_sel !== grp) col_bad++;
        end
        check("report done", cyc < 5000, 1);
        check("column held", col_bad, 0);
        check("words", sgr_central_inst.got.size(), 16);
        for (int k = 0; k < 16; k++) check("word", sgr_central_inst.got[k], {4'ha, grp, 4'h0, k[3:0]});
        check("tx_valid", tx_valid, 0);
    endtask : run_report
    task automatic eavesdrop;
        watch_en = 1'b1;
        sgr_central_inst.got.delete();
        check("store reset", store_out[31:0], 0);
        sgr_central_inst.send_word({watch_addr, 1'b0, 4'h2, 1'b1, 3'h0}, 1'b0);
        repeat (3) @(negedge clk);
        check("armed", busy, 1);
        for (int k = 0; k < 16; k++) begin
            if (k == 8) sgr_central_inst.send_word(17'h0aa50, 1'b1);
            sgr_central_inst.send_word({1'b0, k[3:0], 4'hc, ~k[3:0], 4'h0}, 1'b0);
        end
        repeat (4) @(negedge clk);
        check("idle", busy, 0);
        check("no reply", sgr_central_inst.got.size(), 0);
        for (int k = 0; k < 16; k++) check("unit", store_out[16*k +: 16], {k[3:0], 4'hc, ~k[3:0], 4'h0});
    endtask : eavesdrop
    initial begin
        srst = 1'b1;
        own_addr = 8'h21;
        watch_addr = 8'h33;
        watch_en = 1'b0;
        interleave_en = 1'b0;
        stall = 1'b0;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        refused();
        run_report(4'h5, 0, cyc_a);
        interleave_en = 1'b1;
        run_report(4'hf, 0, cyc_b);
        check("step pace", cyc_b >= 15 * STEP, 1);
        check("release saved", cyc_a - cyc_b >= 15 * REL, 1);
        interleave_en = 1'b0;
        // Long stall fills the reply FIFO and holds the stepping
        run_report(4'h0, 600, cyc_c);
        check("stall held", cyc_c >= 600 + 6 * STEP, 1);
        eavesdrop();
        finish_test();
    end
    initial begin
        #300000;
        bad_count++;
        finish_test();
    end
endmodule : testbench
